// [hw/flow_defines.svh]
// Offsets, field positions and reset values of the flow control block
`ifndef FLOW_DEFINES_SVH
`define FLOW_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CFG            4'h1
`define OFS_FLOW           4'h5
`define OFS_ERR            4'h8
`define OFS_OVR            4'hA

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_ABORT          7
`define BIT_TRIGGER        6
`define BIT_RESTART        5
`define BIT_ALT_READY      4
`define BIT_ENABLE         0
`define BIT_SEQUENCE_TRIGGER_MODE      1
`define BIT_DBUF           2
`define BIT_SOFT_RST       3
`define SRC_HI             5
`define SRC_LO             4
`define BIT_SEQUENCE_TRIGGER_ERR       3
`define BIT_RESTART_ERR    2
`define BIT_ALT_ERR        1
`define BIT_RESTART_OVR    0
`define BIT_ABORT_OVR      1

// ----------------------------------------------------------------------------
// Encodings, flag bank layout and reset values
// ----------------------------------------------------------------------------
`define SRC_BUS            2'h0
`define SRC_INTERNAL       2'h1
`define FLG_RESTART_ERR    0
`define FLG_ALT_ERR        1
`define FLG_SEQUENCE_TRIGGER_ERR       2
`define FLG_RESTART_OVR    3
`define FLG_ABORT_OVR      4
`define FLG_COUNT          5
`define RST_BYTE           8'h00
`define RST_FLAGS          5'h00

`endif

// [hw/flow_pkg.sv]
// Types shared by the flow control block
package flow_pkg;
  typedef logic [3:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] src_sel_t;
endpackage

// [hw/flow_if.sv]
// Carrier between the flow control core and its sticky flag bank
`timescale 1ns/1ps
interface flow_if #(parameter int N = 5);
  logic [N-1:0] set;
  logic [N-1:0] w1c;
  logic [N-1:0] flags;
  logic         clr;
  modport ctrl (output set, output w1c, output clr, input flags);
  modport bank (input set, input w1c, input clr, output flags);
endinterface

// [hw/flow_error_flags.sv]
// Sticky error and overrun flag bank
`timescale 1ns/1ps
`include "flow_defines.svh"
module flow_error_flags #(
  parameter int N = 5
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  flow_if.bank      fb
);
  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  // ----------------------------------------------------------------------------
  // Next value: set beats write-one-clear so no event is lost
  // ----------------------------------------------------------------------------
  always_comb begin
    flags_nxt = fb.clr ? '0 : ((flags_r & ~fb.w1c) | fb.set);
  end

  // Register only
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fb.flags = flags_r;
endmodule // flow_error_flags

// [hw/adc_restart_alt_list_ready_input_flow_control.sv]
// Restart and alternate list flow control of a converter sequencer
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "flow_defines.svh"
module adc_restart_alt_list_ready_input_flow_control (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_in,
  input  wire flow_pkg::addr_t addr_in,
  input  wire flow_pkg::byte_t wr_data_in,
  input  wire logic           wr_in,
  input  wire logic           rd_in,
  output flow_pkg::byte_t     rd_data_out,
  input  wire logic           restart_in,
  input  wire logic           alt_list_ready_input_in,
  input  wire logic           seq_abort_in,
  input  wire logic           trigger_in,
  input  wire logic           stop_exit_in,
  input  wire logic           engine_idle_in,
  input  wire logic           at_list_end_in,
  input  wire logic           cmd_loaded_in,
  input  wire logic           abort_done_in,
  input  wire logic           sample_start_in,
  output logic                restart_request_out,
  output logic                alt_list_ready_out,
  output logic                sequence_trigger_out,
  output logic                sequence_abort_out,
  output logic                fetch_top_out,
  output logic                list_swap_out,
  output logic                restart_error_flag_out,
  output logic                alt_list_error_flag_out,
  output logic                trigger_error_flag_out,
  output logic                restart_overrun_out,
  output logic                abort_overrun_out
);
  import flow_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic     en_r,    en_nxt;
  logic     tmode_r, tmode_nxt;
  logic     dbm_r,   dbm_nxt;
  src_sel_t src_r,   src_nxt;
  logic     restart_request_r,  restart_request_nxt;
  logic     alt_list_ready_r,  alt_list_ready_nxt;
  logic     sequence_trigger_r,  sequence_trigger_nxt;
  logic     abort_r, abort_nxt;
  logic     first_r, first_nxt;
  logic     fetch_r, fetch_nxt;
  logic     swap_r,  swap_nxt;
  byte_t    rdata_r, rdata_nxt;

  logic     soft_rst;
  logic     hold_clr;
  logic     bus_src;
  logic     int_src;
  logic     wr_flow;
  logic     rs_req;
  logic     tr_req;
  logic     ab_req;
  logic     alt_list_ready_flag;
  logic     alt_list_ready_set;
  logic     restart_evt;
  logic     eol_or_abort;
  logic     auto_abort;
  logic     auto_sequence_trigger;
  logic     swap;
  logic     sequence_trigger_err_set;
  logic     alt_err_set;

  flow_if #(.N(`FLG_COUNT)) fi ();

  flow_error_flags #(.N(`FLG_COUNT)) u_flags (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .fb         (fi)
  );

  // ----------------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------------
  // Only one source may steer the bits, so a stray bus write cannot race logic
  always_comb begin
    soft_rst  = wr_in && (addr_in == `OFS_CFG) && wr_data_in[`BIT_SOFT_RST];
    hold_clr  = !en_r || soft_rst;
    bus_src   = (src_r == `SRC_BUS);
    int_src   = (src_r == `SRC_INTERNAL);
    wr_flow   = wr_in && (addr_in == `OFS_FLOW) && bus_src;
    rs_req    = (wr_flow && wr_data_in[`BIT_RESTART]) || (int_src && restart_in);
    tr_req    = (wr_flow && wr_data_in[`BIT_TRIGGER]) || (int_src && trigger_in);
    ab_req    = (wr_flow && wr_data_in[`BIT_ABORT]) || (int_src && seq_abort_in);
    alt_list_ready_flag = bus_src ? wr_data_in[`BIT_ALT_READY] : alt_list_ready_input_in;
    alt_list_ready_set  = rs_req && alt_list_ready_flag && dbm_r && !hold_clr;
  end

  // ----------------------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------------------
  always_comb begin
    restart_evt  = rs_req && !restart_request_r && !hold_clr;
    eol_or_abort = at_list_end_in || abort_r || ab_req;
    auto_abort   = restart_evt && !eol_or_abort;
    auto_sequence_trigger    = restart_evt && tmode_r && eol_or_abort;
    swap         = restart_request_r && cmd_loaded_in && alt_list_ready_r && !hold_clr;
    sequence_trigger_err_set = !hold_clr && ((tr_req && sequence_trigger_r) || (rs_req && tr_req && !tmode_r));
    alt_err_set  = restart_evt && !tmode_r && !alt_list_ready_r && !alt_list_ready_set
                   && !ab_req && !abort_r && !first_r;
  end

  // ----------------------------------------------------------------------------
  // Flag bank drive
  // ----------------------------------------------------------------------------
  // Overruns made sticky
  always_comb begin
    fi.set = '0;
    fi.set[`FLG_RESTART_ERR] = auto_abort;
    fi.set[`FLG_ALT_ERR]     = alt_err_set;
    fi.set[`FLG_SEQUENCE_TRIGGER_ERR]    = sequence_trigger_err_set;
    fi.set[`FLG_RESTART_OVR] = rs_req && restart_request_r && !hold_clr;
    fi.set[`FLG_ABORT_OVR]   = ab_req && abort_r && !hold_clr;
    fi.w1c = '0;
    fi.w1c[`FLG_RESTART_ERR] = wr_in && (addr_in == `OFS_ERR) && wr_data_in[`BIT_RESTART_ERR];
    fi.w1c[`FLG_ALT_ERR]     = wr_in && (addr_in == `OFS_ERR) && wr_data_in[`BIT_ALT_ERR];
    fi.w1c[`FLG_RESTART_OVR] = wr_in && (addr_in == `OFS_OVR) && wr_data_in[`BIT_RESTART_OVR];
    fi.w1c[`FLG_ABORT_OVR]   = wr_in && (addr_in == `OFS_OVR) && wr_data_in[`BIT_ABORT_OVR];
    fi.clr = hold_clr;
  end

  // ----------------------------------------------------------------------------
  // Configuration next values
  // ----------------------------------------------------------------------------
  always_comb begin
    en_nxt    = en_r;
    tmode_nxt = tmode_r;
    dbm_nxt   = dbm_r;
    src_nxt   = src_r;
    if (wr_in && (addr_in == `OFS_CFG)) begin
      en_nxt    = wr_data_in[`BIT_ENABLE];
      tmode_nxt = wr_data_in[`BIT_SEQUENCE_TRIGGER_MODE];
      dbm_nxt   = wr_data_in[`BIT_DBUF];
      src_nxt   = wr_data_in[`SRC_HI:`SRC_LO];
    end
  end

  // ----------------------------------------------------------------------------
  // Flow bit next values
  // ----------------------------------------------------------------------------
  // Sets beat hardware clears for ready, trigger and abort; a restart while restart_request_r is set is dropped as an overrun
  always_comb begin
    restart_request_nxt  = hold_clr ? 1'b0 : (restart_evt || (restart_request_r && !cmd_loaded_in));
    alt_list_ready_nxt  = (hold_clr || !dbm_r) ? 1'b0 : (alt_list_ready_set || (alt_list_ready_r && !swap));
    sequence_trigger_nxt  = hold_clr ? 1'b0 : (tr_req || auto_sequence_trigger || (sequence_trigger_r && !sample_start_in));
    abort_nxt = hold_clr ? 1'b0 : (ab_req || auto_abort || (abort_r && !abort_done_in));
    // Re-armed while disabled, on stop exit and on soft reset
    first_nxt = (hold_clr || stop_exit_in) ? 1'b1 : (first_r && !restart_evt);
    fetch_nxt = restart_request_r && engine_idle_in && !cmd_loaded_in && !hold_clr;
    swap_nxt  = swap;
  end

  // ----------------------------------------------------------------------------
  // Read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = `RST_BYTE;
    if (rd_in) begin
      case (addr_in)
        `OFS_CFG: begin
          rdata_nxt[`BIT_ENABLE]    = en_r;
          rdata_nxt[`BIT_SEQUENCE_TRIGGER_MODE] = tmode_r;
          rdata_nxt[`BIT_DBUF]      = dbm_r;
          rdata_nxt[`SRC_HI:`SRC_LO] = src_r;
        end
        `OFS_FLOW: begin
          rdata_nxt[`BIT_ABORT]     = abort_r;
          rdata_nxt[`BIT_TRIGGER]   = sequence_trigger_r;
          rdata_nxt[`BIT_RESTART]   = restart_request_r;
          rdata_nxt[`BIT_ALT_READY] = alt_list_ready_r;
        end
        `OFS_ERR: begin
          rdata_nxt[`BIT_SEQUENCE_TRIGGER_ERR]    = fi.flags[`FLG_SEQUENCE_TRIGGER_ERR];
          rdata_nxt[`BIT_RESTART_ERR] = fi.flags[`FLG_RESTART_ERR];
          rdata_nxt[`BIT_ALT_ERR]     = fi.flags[`FLG_ALT_ERR];
        end
        `OFS_OVR: begin
          rdata_nxt[`BIT_RESTART_OVR] = fi.flags[`FLG_RESTART_OVR];
          rdata_nxt[`BIT_ABORT_OVR]   = fi.flags[`FLG_ABORT_OVR];
        end
        default: begin
          rdata_nxt = `RST_BYTE; // Unmapped reads as zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_r    <= 1'b0;
      tmode_r <= 1'b0;
      dbm_r   <= 1'b0;
      src_r   <= `SRC_BUS;
      restart_request_r  <= 1'b0;
      alt_list_ready_r  <= 1'b0;
      sequence_trigger_r  <= 1'b0;
      abort_r <= 1'b0;
      first_r <= 1'b1;
      fetch_r <= 1'b0;
      swap_r  <= 1'b0;
      rdata_r <= `RST_BYTE;
    end else begin
      en_r    <= en_nxt;
      tmode_r <= tmode_nxt;
      dbm_r   <= dbm_nxt;
      src_r   <= src_nxt;
      restart_request_r  <= restart_request_nxt;
      alt_list_ready_r  <= alt_list_ready_nxt;
      sequence_trigger_r  <= sequence_trigger_nxt;
      abort_r <= abort_nxt;
      first_r <= first_nxt;
      fetch_r <= fetch_nxt;
      swap_r  <= swap_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------------------
  assign rd_data_out             = rdata_r;
  assign restart_request_out     = restart_request_r;
  assign alt_list_ready_out      = alt_list_ready_r;
  assign sequence_trigger_out    = sequence_trigger_r;
  assign sequence_abort_out      = abort_r;
  assign fetch_top_out           = fetch_r;
  assign list_swap_out           = swap_r;
  assign restart_error_flag_out  = fi.flags[`FLG_RESTART_ERR];
  assign alt_list_error_flag_out = fi.flags[`FLG_ALT_ERR];
  assign trigger_error_flag_out  = fi.flags[`FLG_SEQUENCE_TRIGGER_ERR];
  assign restart_overrun_out     = fi.flags[`FLG_RESTART_OVR];
  assign abort_overrun_out       = fi.flags[`FLG_ABORT_OVR];

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_fetch_top;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_request_r && engine_idle_in && !cmd_loaded_in && !hold_clr |=> fetch_top_out ##1 !fetch_top_out || restart_request_r;
  endproperty
  a_fetch_top: assert property (p_fetch_top) else $error("fetch request missing");

  property p_restart_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_request_r && cmd_loaded_in |=> !restart_request_out;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart not cleared");

  property p_enable_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
    !en_r |=> !restart_request_out && !alt_list_ready_out;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("bits set while disabled");

  property p_zero_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_flow && !wr_data_in[`BIT_RESTART] |=> restart_request_out == $past(restart_request_r && !cmd_loaded_in && !hold_clr);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write changed restart");

  property p_overrun;
    @(posedge ref_clk_in) disable iff (rst_in)
    rs_req && restart_request_r && !hold_clr |=> restart_overrun_out;
  endproperty
  a_overrun: assert property (p_overrun) else $error("restart overrun lost");

  property p_auto_sequence_trigger;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_evt && tmode_r && at_list_end_in |=> sequence_trigger_out && restart_request_out;
  endproperty
  a_auto_sequence_trigger: assert property (p_auto_sequence_trigger) else $error("trigger not set with restart");

  property p_swap;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_request_r && alt_list_ready_r && cmd_loaded_in && !hold_clr && !alt_list_ready_set |=> list_swap_out && !alt_list_ready_out;
  endproperty
  a_swap: assert property (p_swap) else $error("list swap missing");

  property p_dbuf_force;
    @(posedge ref_clk_in) disable iff (rst_in)
    !dbm_r |=> !alt_list_ready_out;
  endproperty
  a_dbuf_force: assert property (p_dbuf_force) else $error("ready set without double buffer");

  property p_ready_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    alt_list_ready_r && wr_flow && dbm_r && !hold_clr && !swap |=> alt_list_ready_out;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("bus write cleared ready");

  property p_ready_sample;
    @(posedge ref_clk_in) disable iff (rst_in)
    int_src && restart_in && !alt_list_ready_r |=> alt_list_ready_out == $past(alt_list_ready_input_in && dbm_r && !hold_clr);
  endproperty
  a_ready_sample: assert property (p_ready_sample) else $error("ready input not sampled");

  property p_alt_err;
    @(posedge ref_clk_in) disable iff (rst_in)
    alt_err_set |=> alt_list_error_flag_out;
  endproperty
  a_alt_err: assert property (p_alt_err) else $error("missing list error lost");

  property p_first_exempt;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_evt && first_r && !alt_list_error_flag_out && !soft_rst |=> !alt_list_error_flag_out;
  endproperty
  a_first_exempt: assert property (p_first_exempt) else $error("first restart raised error");

  property p_sequence_trigger_combo;
    @(posedge ref_clk_in) disable iff (rst_in)
    rs_req && tr_req && !tmode_r && !hold_clr |=> trigger_error_flag_out;
  endproperty
  a_sequence_trigger_combo: assert property (p_sequence_trigger_combo) else $error("restart with trigger not flagged");

  property p_abort_combo;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_evt && ab_req |-> !fi.set[`FLG_RESTART_ERR] && !fi.set[`FLG_ALT_ERR];
  endproperty
  a_abort_combo: assert property (p_abort_combo) else $error("abort restart raised error");

  property p_auto_abort;
    @(posedge ref_clk_in) disable iff (rst_in)
    restart_evt && !at_list_end_in && !abort_r && !ab_req |=> sequence_abort_out && restart_error_flag_out;
  endproperty
  a_auto_abort: assert property (p_auto_abort) else $error("premature restart not aborted");

  property p_sequence_trigger_ovr;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_flow && wr_data_in[`BIT_TRIGGER] && sequence_trigger_r && !hold_clr |=> trigger_error_flag_out && sequence_trigger_out;
  endproperty
  a_sequence_trigger_ovr: assert property (p_sequence_trigger_ovr) else $error("trigger overrun mishandled");
endmodule // adc_restart_alt_list_ready_input_flow_control

// [dv/flow_engine_model.sv]
// Behavioural model of the conversion engine beside the flow control block
`timescale 1ns/1ps
module flow_engine_model (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic stall_in,
  input  wire logic fetch_top_in,
  input  wire logic abort_in,
  input  wire logic trigger_in,
  output logic      engine_idle_out,
  output logic      cmd_loaded_out,
  output logic      abort_done_out,
  output logic      sample_start_out
);
  // Busy while stalled, so no fetch can complete behind the bench's back
  assign engine_idle_out = !stall_in;
  // -------------------------------------------------------------------------
  // One-cycle completion pulses, held off while stalled
  // -------------------------------------------------------------------------
  // load ends restart
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_loaded_out   <= 1'b0;
      abort_done_out   <= 1'b0;
      sample_start_out <= 1'b0;
    end else begin
      cmd_loaded_out   <= fetch_top_in & !stall_in & !cmd_loaded_out;
      abort_done_out   <= abort_in & !stall_in & !abort_done_out;
      sample_start_out <= trigger_in & !stall_in & !sample_start_out;
    end
  end
endmodule // flow_engine_model

// [dv/adc_restart_alt_list_ready_input_flow_control_bench.sv]
// Self-checking testbench of the restart and alternate list flow control
`timescale 1ns/1ps
`include "flow_defines.svh"
module adc_restart_alt_list_ready_input_flow_control_bench;
  import flow_pkg::*;
  logic  ref_clk_in, rst_in, wr_in, rd_in, restart_in, alt_in, at_end, stall;
  logic  idle, loaded, abort_done, smp, fetch, swap, rq, rdy, trg, abt;
  logic  tin, ain, stop_x;
  wire   [4:0] flg; // Sticky flags in flag bank order
  addr_t addr_in;
  byte_t wr_data_in, rd_data_out, d;
  int    failures, compares, swaps;
  adc_restart_alt_list_ready_input_flow_control adc_restart_alt_list_ready_input_flow_control_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .restart_in(restart_in),
    .alt_list_ready_input_in(alt_in), .seq_abort_in(ain), .trigger_in(tin),
    .stop_exit_in(stop_x), .engine_idle_in(idle), .at_list_end_in(at_end),
    .cmd_loaded_in(loaded), .abort_done_in(abort_done), .sample_start_in(smp),
    .restart_request_out(rq), .alt_list_ready_out(rdy), .sequence_trigger_out(trg),
    .sequence_abort_out(abt), .fetch_top_out(fetch), .list_swap_out(swap),
    .restart_error_flag_out(flg[0]), .alt_list_error_flag_out(flg[1]), .trigger_error_flag_out(flg[2]),
    .restart_overrun_out(flg[3]), .abort_overrun_out(flg[4]));
  flow_engine_model flow_engine_model_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .stall_in(stall), .fetch_top_in(fetch),
    .abort_in(abt), .trigger_in(trg), .engine_idle_out(idle), .cmd_loaded_out(loaded),
    .abort_done_out(abort_done), .sample_start_out(smp));
  // -------------------------------------------------------------------------
  // Clock, swap counter and bus tasks
  // -------------------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // Counted mid-cycle so a check at the next rising edge never races it
  always @(negedge ref_clk_in) if (swap === 1'b1) swaps++;
  task automatic check(input byte_t seen, input byte_t exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input addr_t a, input byte_t v);
    @(posedge ref_clk_in);
    addr_in <= a; wr_data_in <= v; wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input addr_t a, input byte_t exp);
    @(posedge ref_clk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 check(rd_data_out, exp);
  endtask
  // Internal restart pulse with the ready level beside it
  task automatic pulse(input logic ready);
    @(posedge ref_clk_in);
    restart_in <= 1'b1; alt_in <= ready;
    @(posedge ref_clk_in);
    restart_in <= 1'b0;
  endtask
  // Let the engine finish, bounded wait for all flow bits to clear
  task automatic drain();
    int n;
    stall <= 1'b0;
    n = 0;
    while ({rq, rdy, trg, abt} !== 4'h0 && n < 60) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (n >= 60) check(8'h01, 8'h00);
    stall <= 1'b1;
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    results();
  end
  // -------------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------------
  initial begin
    rst_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0; addr_in = 4'h0; wr_data_in = 8'h00;
    restart_in = 1'b0; alt_in = 1'b0; at_end = 1'b1; stall = 1'b1;
    tin = 1'b0; ain = 1'b0; stop_x = 1'b0;
    failures = 0; compares = 0; swaps = 0;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // Paired restart and ready, then swap on load
    wr(`OFS_CFG, 8'h05);
    wr(`OFS_FLOW, 8'h30);
    rd(`OFS_FLOW, 8'h30);
    rd(`OFS_ERR, 8'h00);
    drain();
    check(8'(swaps), 8'h01);
    $display("test paired restart done");
    // Second restart without ready, zero write and overrun
    wr(`OFS_FLOW, 8'h20);
    rd(`OFS_ERR, 8'h02);
    check(8'(flg), 8'h02);
    wr(`OFS_ERR, 8'h02);
    rd(`OFS_ERR, 8'h00);
    wr(`OFS_FLOW, 8'h00);
    rd(`OFS_FLOW, 8'h20);
    wr(`OFS_FLOW, 8'h20);
    rd(`OFS_OVR, 8'h01);
    check(8'(flg), 8'h08);
    rd(`OFS_ERR, 8'h00);
    drain();
    wr(`OFS_FLOW, 8'h40);
    wr(`OFS_FLOW, 8'h40);
    rd(`OFS_ERR, 8'h08);
    $display("test overrun done");
    // Soft reset, restart before list end forces abort
    wr(`OFS_CFG, 8'h0D);
    rd(`OFS_OVR, 8'h00);
    at_end <= 1'b0;
    wr(`OFS_FLOW, 8'h20);
    rd(`OFS_FLOW, 8'hA0);
    rd(`OFS_ERR, 8'h04);
    // Second abort while the first is pending is an overrun
    wr(`OFS_FLOW, 8'h80);
    rd(`OFS_OVR, 8'h02);
    check(8'(flg), 8'h11);
    drain();
    wr(`OFS_ERR, 8'h04);
    wr(`OFS_FLOW, 8'hA0);
    rd(`OFS_ERR, 8'h00);
    drain();
    at_end <= 1'b1;
    wr(`OFS_FLOW, 8'h70);
    rd(`OFS_ERR, 8'h08);
    drain();
    $display("test abort and error done");
    // Trigger mode sets trigger with restart
    wr(`OFS_CFG, 8'h0F);
    wr(`OFS_FLOW, 8'h20);
    rd(`OFS_FLOW, 8'h60);
    rd(`OFS_ERR, 8'h00);
    drain();
    // Ready forced zero without double buffering
    wr(`OFS_CFG, 8'h09);
    wr(`OFS_FLOW, 8'h30);
    rd(`OFS_FLOW, 8'h20);
    drain();
    $display("test modes done");
    // Internal source: bus refused, pulses set bits
    wr(`OFS_CFG, 8'h1D);
    wr(`OFS_FLOW, 8'h20);
    rd(`OFS_FLOW, 8'h00);
    pulse(1'b1);
    rd(`OFS_FLOW, 8'h30);
    pulse(1'b0);
    rd(`OFS_OVR, 8'h01);
    drain();
    // Stop exit re-arms the first-restart exemption
    stop_x <= 1'b1;
    @(posedge ref_clk_in);
    stop_x <= 1'b0;
    pulse(1'b0);
    rd(`OFS_FLOW, 8'h20);
    rd(`OFS_ERR, 8'h00);
    drain();
    // Internal trigger and abort, each twice
    repeat (2) begin
      @(posedge ref_clk_in);
      tin <= 1'b1; ain <= 1'b1;
      @(posedge ref_clk_in);
      tin <= 1'b0; ain <= 1'b0;
    end
    rd(`OFS_FLOW, 8'hC0);
    check(8'(flg), 8'h1C);
    // Disabled converter refuses everything
    wr(`OFS_CFG, 8'h00);
    wr(`OFS_FLOW, 8'h30);
    rd(`OFS_FLOW, 8'h00);
    check(8'(flg), 8'h00);
    rd(4'hF, 8'h00);
    $display("test internal and disable done");
    results();
  end
endmodule // adc_restart_alt_list_ready_input_flow_control_bench
